// ===== inc/test_bus_pkg.sv
// Constants and types shared by the test bus control logic
package test_bus_pkg;

   // Register offsets on the configuration port
   localparam logic [7:0] OFS_SELECT   = 8'h70;
   localparam logic [7:0] OFS_MONITOR  = 8'h74;
   localparam logic [7:0] OFS_CTRL_1   = 8'h78;
   localparam logic [7:0] OFS_CTRL_2   = 8'h7C;

   // Values after reset
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [7:0] CTRL_1_RESET = 8'h00;
   localparam logic [7:0] CTRL_2_RESET = 8'h00;
   localparam logic [8:0] PN_SEED      = 9'h1FF;

   // Test bus selections handled here
   localparam logic [7:0] SEL_XOR_FAST = 8'h17;
   localparam logic [7:0] SEL_TIMING   = 8'h18;
   localparam logic [7:0] SEL_CAL_LO   = 8'h19;
   localparam logic [7:0] SEL_CAL_HI   = 8'h1A;
   localparam logic [7:0] SEL_FREQ_LO  = 8'h1B;
   localparam logic [7:0] SEL_XOR_SLOW = 8'h1C;
   localparam logic [7:0] SEL_SQ2_HI   = 8'h1D;
   localparam logic [7:0] SEL_RSVD_A   = 8'h1E;
   localparam logic [7:0] SEL_RSVD_B   = 8'h1F;

   // Field positions in the first test control register
   localparam int CTRL_1_PN_EN     = 7;
   localparam int CTRL_1_MUX_ALT   = 6;
   localparam int CTRL_1_HR_XOR    = 5;
   localparam int CTRL_1_RAND_ADDR = 4;
   localparam int CTRL_1_FAST_CAL  = 3;
   localparam int CTRL_1_CAL_OVR   = 2;
   localparam int CTRL_1_ADC_TEST  = 1;
   localparam int CTRL_1_LOOPBACK  = 0;

   // Field positions in the second test control register
   localparam int CTRL_2_ED_CONT   = 1;
   localparam int CTRL_2_CCA_LATCH = 0;

   // Timing
   localparam int CLK_HZ           = 20_000_000;
   localparam int ED_STOP_NS       = 19_000;
   localparam int ED_STOP_CYCLES   = (ED_STOP_NS * (CLK_HZ / 1_000_000)) / 1_000;
   localparam int CAL_SLOW_HZ      = 1_000;
   localparam int CAL_FAST_HZ      = 22_000;
   localparam int CAL_SLOW_CYCLES  = CLK_HZ / CAL_SLOW_HZ;
   localparam int CAL_FAST_CYCLES  = CLK_HZ / CAL_FAST_HZ;
   localparam int CAL_CNT_W        = 15;
   localparam int ED_CNT_W         = 9;

   typedef enum logic [1:0] {ED_IDLE, ED_WINDOW, ED_HOLD} ed_state_e;

endpackage

// ===== inc/test_aux_if.sv
// Interface between the test bus control and its helper generators
`timescale 1ns/1ps
interface test_aux_if;
   logic       pn_run;
   logic [8:0] pn_state;
   logic       cal_fast;
   logic       cal_tick;

   modport ctrl_mp (output pn_run, output cal_fast,
                    input  pn_state, input cal_tick);
   modport pn_mp   (input  pn_run, output pn_state);
   modport div_mp  (input  cal_fast, output cal_tick);
endinterface

// ===== logic/pn_sequence_gen.sv
// Nine-bit pseudo-noise generator for fault test and random addresses
`timescale 1ns/1ps
module pn_sequence_gen (
   input  wire logic clk,
   input  wire logic rst_b,
   test_aux_if.pn_mp aux
);
   logic [8:0] state_q;

   // Maximal length sequence, polynomial x^9 + x^5 + 1
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= test_bus_pkg::PN_SEED;
      end else if (aux.pn_run) begin
         state_q <= {state_q[7:0], state_q[8] ^ state_q[4]};
      end
   end

   assign aux.pn_state = state_q;
endmodule

// ===== logic/cal_tick_divider.sv
// Divider making the calibration update tick at a slow or fast rate
`timescale 1ns/1ps
module cal_tick_divider #(
   parameter int SLOW_CYCLES = test_bus_pkg::CAL_SLOW_CYCLES,
   parameter int FAST_CYCLES = test_bus_pkg::CAL_FAST_CYCLES,
   parameter int CNT_W       = test_bus_pkg::CAL_CNT_W
) (
   input  wire logic  clk,
   input  wire logic  rst_b,
   test_aux_if.div_mp aux
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic             tick_q;

   assign limit = aux.cal_fast ? CNT_W'(FAST_CYCLES - 1)
                               : CNT_W'(SLOW_CYCLES - 1);

   // A rate change takes effect at once, the count restarts if above limit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (cnt_q >= limit) begin
         cnt_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + CNT_W'(1);
         tick_q <= 1'b0;
      end
   end

   assign aux.cal_tick = tick_q;
endmodule

// ===== logic/test_bus_control.sv
// Test bus multiplexer, monitor and test control registers
`timescale 1ns/1ps
module test_bus_control #(
   parameter int CAL_SLOW_CYCLES = test_bus_pkg::CAL_SLOW_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic      [7:0]  test_pins,
   output logic             test_strobe,
   input  wire logic [8:0]  xor_low_fast,
   input  wire logic [7:0]  xor_low_slow,
   input  wire logic [8:0]  xor_high_rate,
   input  wire logic        timing_jump_clock,
   input  wire logic        timing_jump_count,
   input  wire logic        symbol_rate_clock,
   input  wire logic [4:0]  master_timing_count,
   input  wire logic        sample_clock,
   input  wire logic [17:0] cal_accum,
   input  wire logic [15:0] freq_accum,
   input  wire logic [15:0] signal_quality_second,
   input  wire logic        sq2_valid,
   input  wire logic [4:0]  cal_override_register,
   input  wire logic [4:0]  auto_cal_bits,
   output logic      [4:0]  cal_bits,
   output logic             cal_update_tick,
   output logic      [8:0]  pn_fault_data,
   output logic             subsample_mux_alt,
   input  wire logic [5:0]  adc_rssi,
   input  wire logic [2:0]  adc_i,
   input  wire logic [2:0]  adc_q,
   output logic      [11:0] adc_test_pins,
   output logic             modem_disable,
   input  wire logic [2:0]  tx_i,
   input  wire logic [2:0]  tx_q,
   output logic      [2:0]  modem_i,
   output logic      [2:0]  modem_q,
   input  wire logic        receive_power_enable,
   input  wire logic        antenna_dwell,
   input  wire logic        energy_compare,
   input  wire logic        raw_channel_clear,
   output logic             energy_detect_run,
   output logic             energy_detect,
   output logic             channel_clear_indication
);
   logic [7:0]                      select_q;
   logic [7:0]                      ctrl_1_q;
   logic [7:0]                      ctrl_2_q;
   logic [8:0]                      bus_d;
   logic [7:0]                      test_pins_q;
   logic                            test_strobe_q;
   logic                            rpe_q;
   logic                            rpe_rise;
   test_bus_pkg::ed_state_e         ed_state_q;
   logic [test_bus_pkg::ED_CNT_W-1:0] ed_cnt_q;
   logic                            ed_run_q;
   logic                            ed_q;
   logic                            cca_raw_q;
   logic                            cca_snap_q;
   logic                            cca_snap_done_q;

   test_aux_if aux ();

   // Register address decode, for writes and reads
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Configuration registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         select_q <= test_bus_pkg::SELECT_RESET;
         ctrl_1_q <= test_bus_pkg::CTRL_1_RESET;
         ctrl_2_q <= test_bus_pkg::CTRL_2_RESET;
      end else if (reg_wr) begin
         if (hit(reg_addr, test_bus_pkg::OFS_SELECT)) begin
            select_q <= reg_wdata;
         end
         if (hit(reg_addr, test_bus_pkg::OFS_CTRL_1)) begin
            ctrl_1_q <= reg_wdata;
         end
         if (hit(reg_addr, test_bus_pkg::OFS_CTRL_2)) begin
            ctrl_2_q <= reg_wdata;
         end
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (hit(reg_addr, test_bus_pkg::OFS_SELECT)) begin
            reg_rdata <= select_q;
         end else if (hit(reg_addr, test_bus_pkg::OFS_MONITOR)) begin
            reg_rdata <= test_pins_q;
         end else if (hit(reg_addr, test_bus_pkg::OFS_CTRL_1)) begin
            reg_rdata <= ctrl_1_q;
         end else if (hit(reg_addr, test_bus_pkg::OFS_CTRL_2)) begin
            reg_rdata <= ctrl_2_q;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // Helper generators
   assign aux.pn_run   = ctrl_1_q[test_bus_pkg::CTRL_1_PN_EN]
                       | ctrl_1_q[test_bus_pkg::CTRL_1_RAND_ADDR];
   assign aux.cal_fast = ctrl_1_q[test_bus_pkg::CTRL_1_FAST_CAL];

   pn_sequence_gen u_pn (
      .clk   (clk),
      .rst_b (rst_b),
      .aux   (aux.pn_mp)
   );

   cal_tick_divider #(
      .SLOW_CYCLES (CAL_SLOW_CYCLES)
   ) u_cal_div (
      .clk   (clk),
      .rst_b (rst_b),
      .aux   (aux.div_mp)
   );

   // Test bus source, bit 8 goes to the strobe pin
   always_comb begin
      bus_d = 9'h000;
      if (ctrl_1_q[test_bus_pkg::CTRL_1_HR_XOR]) begin
         bus_d = xor_high_rate;
      end else if (ctrl_1_q[test_bus_pkg::CTRL_1_RAND_ADDR]) begin
         bus_d = aux.pn_state;
      end else begin
         case (select_q)
            test_bus_pkg::SEL_XOR_FAST: begin
               bus_d = xor_low_fast;
            end
            test_bus_pkg::SEL_TIMING: begin
               bus_d = {sample_clock, timing_jump_clock,
                        timing_jump_count, symbol_rate_clock,
                        master_timing_count};
            end
            test_bus_pkg::SEL_CAL_LO: begin
               bus_d = {cal_accum[8], cal_accum[7:0]};
            end
            test_bus_pkg::SEL_CAL_HI: begin
               bus_d = {cal_accum[17], cal_accum[16:9]};
            end
            test_bus_pkg::SEL_FREQ_LO: begin
               bus_d = {freq_accum[15], freq_accum[14:7]};
            end
            test_bus_pkg::SEL_XOR_SLOW: begin
               bus_d = {symbol_rate_clock, xor_low_slow};
            end
            test_bus_pkg::SEL_SQ2_HI: begin
               bus_d = {sq2_valid,
                        signal_quality_second[15:8]};
            end
            test_bus_pkg::SEL_RSVD_A,
            test_bus_pkg::SEL_RSVD_B: begin
               bus_d = 9'h000;
            end
            default: begin
               bus_d = 9'h000;
            end
         endcase
      end
   end

   // Pins change one clock after the source
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         test_pins_q   <= 8'h00;
         test_strobe_q <= 1'b0;
      end else begin
         test_pins_q   <= bus_d[7:0];
         test_strobe_q <= bus_d[8];
      end
   end

   assign test_pins   = test_pins_q;
   assign test_strobe = test_strobe_q;

   // Datapath test controls
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cal_bits          <= 5'h00;
         cal_update_tick   <= 1'b0;
         pn_fault_data     <= 9'h000;
         subsample_mux_alt <= 1'b0;
         adc_test_pins     <= 12'h000;
         modem_disable     <= 1'b0;
         modem_i           <= 3'h0;
         modem_q           <= 3'h0;
      end else begin
         cal_update_tick   <= aux.cal_tick;
         cal_bits          <= ctrl_1_q[test_bus_pkg::CTRL_1_CAL_OVR] ?
                              cal_override_register :
                              auto_cal_bits;
         pn_fault_data     <= ctrl_1_q[test_bus_pkg::CTRL_1_PN_EN] ?
                              aux.pn_state : 9'h000;
         subsample_mux_alt <=
            ctrl_1_q[test_bus_pkg::CTRL_1_MUX_ALT];
         modem_disable     <= ctrl_1_q[test_bus_pkg::CTRL_1_ADC_TEST];
         adc_test_pins     <= ctrl_1_q[test_bus_pkg::CTRL_1_ADC_TEST] ?
                              {adc_rssi, adc_i, adc_q} :
                              12'h000;
         if (ctrl_1_q[test_bus_pkg::CTRL_1_LOOPBACK]) begin
            modem_i <= tx_i;
            modem_q <= tx_q;
         end else begin
            modem_i <= adc_i;
            modem_q <= adc_q;
         end
      end
   end

   assign rpe_rise = receive_power_enable & ~rpe_q;

   // Energy detect window after receive enable rises
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rpe_q      <= 1'b0;
         ed_state_q <= test_bus_pkg::ED_IDLE;
         ed_cnt_q   <= '0;
         ed_run_q   <= 1'b0;
      end else begin
         rpe_q <= receive_power_enable;
         case (ed_state_q)
            test_bus_pkg::ED_IDLE: begin
               if (rpe_rise) begin
                  ed_state_q <= test_bus_pkg::ED_WINDOW;
                  ed_cnt_q   <= '0;
               end
            end
            test_bus_pkg::ED_WINDOW: begin
               if (!receive_power_enable) begin
                  ed_state_q <= test_bus_pkg::ED_IDLE;
               end else if (ed_cnt_q == test_bus_pkg::ED_CNT_W'(
                            test_bus_pkg::ED_STOP_CYCLES - 1)) begin
                  ed_state_q <= test_bus_pkg::ED_HOLD;
               end else begin
                  ed_cnt_q <= ed_cnt_q + test_bus_pkg::ED_CNT_W'(1);
               end
            end
            test_bus_pkg::ED_HOLD: begin
               if (!receive_power_enable) begin
                  ed_state_q <= test_bus_pkg::ED_IDLE;
               end
            end
            default: begin
               ed_state_q <= test_bus_pkg::ED_IDLE;
            end
         endcase
         ed_run_q <= receive_power_enable
                   & (ctrl_2_q[test_bus_pkg::CTRL_2_ED_CONT]
                      | rpe_rise
                      | (ed_state_q == test_bus_pkg::ED_WINDOW));
      end
   end

   // Energy detect sampled each antenna dwell while energy_detect_run is set, channel clear each dwell
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ed_q            <= 1'b0;
         cca_raw_q       <= 1'b0;
         cca_snap_q      <= 1'b0;
         cca_snap_done_q <= 1'b0;
      end else begin
         if (antenna_dwell && ed_run_q) begin
            ed_q <= energy_compare;
         end
         if (antenna_dwell) begin
            cca_raw_q <= raw_channel_clear;
         end
         // A dwell on the enable edge itself is the first one taken
         if (antenna_dwell && receive_power_enable
             && (rpe_rise || !cca_snap_done_q)) begin
            cca_snap_q      <= raw_channel_clear;
            cca_snap_done_q <= 1'b1;
         end else if (rpe_rise) begin
            cca_snap_done_q <= 1'b0;
         end
      end
   end

   assign energy_detect_run        = ed_run_q;
   assign energy_detect            = ed_q;
   assign channel_clear_indication =
      ctrl_2_q[test_bus_pkg::CTRL_2_CCA_LATCH] ? cca_snap_q : cca_raw_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic plain_sel;
   assign plain_sel = !ctrl_1_q[test_bus_pkg::CTRL_1_HR_XOR]
                    && !ctrl_1_q[test_bus_pkg::CTRL_1_RAND_ADDR];

   sequence s_sel_write;
      reg_wr && reg_addr == 8'h70;
   endsequence

   property p_sel_write;
      s_sel_write |=> select_q == $past(reg_wdata);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("select register did not take the write");

   property p_timing;
      plain_sel && select_q == 8'h18 |=>
         {test_strobe, test_pins} == $past({sample_clock,
          timing_jump_clock, timing_jump_count, symbol_rate_clock,
          master_timing_count});
   endproperty
   a_timing: assert property (p_timing)
      else $error("timing selection pins wrong");

   property p_cal_hi;
      plain_sel && select_q == 8'h1A |=>
         {test_strobe, test_pins} == $past(cal_accum[17:9]);
   endproperty
   a_cal_hi: assert property (p_cal_hi)
      else $error("calibration high selection pins wrong");

   property p_reserved;
      plain_sel && (select_q == 8'h1E || select_q == 8'h1F) |=>
         test_pins == 8'h00 && !test_strobe;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved selection not zero");

   property p_sq2_pulse;
      plain_sel && select_q == 8'h1D && sq2_valid |=> test_strobe;
   endproperty
   a_sq2_pulse: assert property (p_sq2_pulse)
      else $error("quality strobe missing");

   property p_monitor;
      reg_rd && reg_addr == 8'h74 |=> reg_rdata == $past(test_pins);
   endproperty
   a_monitor: assert property (p_monitor)
      else $error("monitor read does not match pins");

   property p_cal_override;
      ctrl_1_q[2] |=> cal_bits == $past(cal_override_register);
   endproperty
   a_cal_override: assert property (p_cal_override)
      else $error("calibration override not applied");

   property p_loopback;
      ctrl_1_q[0] |=> modem_i == $past(tx_i) && modem_q == $past(tx_q);
   endproperty
   a_loopback: assert property (p_loopback)
      else $error("loopback data wrong");

   sequence s_window_end;
      ed_state_q == test_bus_pkg::ED_WINDOW
      && ed_cnt_q == test_bus_pkg::ED_CNT_W'(
         test_bus_pkg::ED_STOP_CYCLES - 1)
      && receive_power_enable;
   endsequence

   property p_ed_stop;
      s_window_end ##1 !ctrl_2_q[1] |=> !energy_detect_run;
   endproperty
   a_ed_stop: assert property (p_ed_stop)
      else $error("energy detect ran past its window");

   property p_cca_latched;
      ctrl_2_q[0] && !$changed(ctrl_2_q) && cca_snap_done_q
      && !rpe_rise && !(reg_wr && reg_addr == 8'h7C)
      |=> $stable(channel_clear_indication);
   endproperty
   a_cca_latched: assert property (p_cca_latched)
      else $error("latched channel clear changed");
endmodule

// ===== tb/tb.sv
// Self-checking bench for the test bus multiplexer and test controls
`timescale 1ns/1ps
module tb;
   localparam int SLOW = 50;
   logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sq2_valid = 0;
   logic        antenna_dwell = 0, energy_compare = 0, raw_channel_clear = 0;
   logic        receive_power_enable = 0, sample_clock = 0;
   logic        timing_jump_clock = 1, timing_jump_count = 0;
   logic        symbol_rate_clock = 1;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, xor_low_slow = 8'h3C;
   logic [8:0]  xor_low_fast = 9'h1A5, xor_high_rate = 9'h0C3;
   logic [4:0]  master_timing_count = 5'h15, auto_cal_bits = 5'h14;
   logic [4:0]  cal_override_register = 5'h0B;
   logic [17:0] cal_accum = 18'h2_B4C7;
   logic [15:0] freq_accum = 16'hC3A5, signal_quality_second = 16'h5AE1;
   logic [5:0]  adc_rssi = 6'h2D;
   logic [2:0]  adc_i = 3'h5, adc_q = 3'h2, tx_i = 3'h3, tx_q = 3'h6;
   logic [7:0]  reg_rdata, test_pins;
   logic        test_strobe, cal_update_tick, subsample_mux_alt;
   logic        modem_disable, energy_detect_run, energy_detect;
   logic        channel_clear_indication;
   logic [4:0]  cal_bits;
   logic [8:0]  pn_fault_data;
   logic [11:0] adc_test_pins;
   logic [2:0]  modem_i, modem_q;
   int          num_errors = 0, total_checks = 0;

   test_bus_control #(.CAL_SLOW_CYCLES(SLOW)) u_dut (.clk, .rst_b,
      .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .test_pins,
      .test_strobe, .xor_low_fast, .xor_low_slow, .xor_high_rate,
      .timing_jump_clock, .timing_jump_count, .symbol_rate_clock,
      .master_timing_count, .sample_clock, .cal_accum, .freq_accum,
      .signal_quality_second, .sq2_valid, .cal_override_register,
      .auto_cal_bits, .cal_bits, .cal_update_tick, .pn_fault_data,
      .subsample_mux_alt, .adc_rssi, .adc_i, .adc_q, .adc_test_pins,
      .modem_disable, .tx_i, .tx_q, .modem_i, .modem_q,
      .receive_power_enable, .antenna_dwell, .energy_compare,
      .raw_channel_clear, .energy_detect_run, .energy_detect,
      .channel_clear_indication);

   always #25 clk = ~clk;

   task automatic conclude();
      if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [17:0] s, input logic [17:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   task automatic dwell();
      @(posedge clk);
      antenna_dwell <= 1'b1;
      @(posedge clk);
      antenna_dwell <= 1'b0;
      cyc(2);
   endtask

   task automatic rpe_rise();
      @(posedge clk);
      receive_power_enable <= 1'b0;
      cyc(3);
      @(posedge clk);
      receive_power_enable <= 1'b1;
   endtask

   function automatic logic [8:0] exp_sel(input logic [7:0] s);
      case (s)
         8'h17: return xor_low_fast;
         8'h18: return {sample_clock, timing_jump_clock, timing_jump_count,
                        symbol_rate_clock, master_timing_count};
         8'h19: return cal_accum[8:0];
         8'h1A: return cal_accum[17:9];
         8'h1B: return freq_accum[15:7];
         8'h1C: return {symbol_rate_clock, xor_low_slow};
         8'h1D: return {1'b0, signal_quality_second[15:8]};
         default: return 9'h000;
      endcase
   endfunction

   task automatic t_regs();
      rd_chk(8'h70, 8'h00);
      rd_chk(8'h78, 8'h00);
      rd_chk(8'h7C, 8'h00);
      wr(8'h7C, 8'h03);
      rd_chk(8'h7C, 8'h03);
      wr(8'h7C, 8'h00);
      wr(8'h74, 8'hFF);
      rd_chk(8'h74, 8'h00);
      rd_chk(8'h55, 8'h00);
   endtask

   task automatic t_sel();
      logic [8:0] e;
      for (int s = 8'h17; s <= 8'h1F; s++) begin
         wr(8'h70, s[7:0]);
         cyc(3);
         e = exp_sel(s[7:0]);
         chk({test_strobe, test_pins}, e);
         rd_chk(8'h74, e[7:0]);
         rd_chk(8'h70, s[7:0]);
      end
      wr(8'h70, 8'h18);
      cyc(3);
      @(posedge clk);
      master_timing_count <= 5'h0A;
      cyc(2);
      chk(test_pins[4:0], 5'h0A);
   endtask

   task automatic t_sq2();
      wr(8'h70, 8'h1D);
      cyc(3);
      @(posedge clk);
      sq2_valid <= 1'b1;
      @(posedge clk);
      sq2_valid <= 1'b0;
      #1;
      chk(test_strobe, 1'b1);
      cyc(1);
      chk({test_strobe, test_pins}, {1'b0, 8'h5A});
   endtask

   task automatic t_ctrl1();
      logic [8:0] p;
      wr(8'h78, 8'h04);
      cyc(2);
      chk(cal_bits, cal_override_register);
      wr(8'h78, 8'h02);
      cyc(2);
      chk(cal_bits, auto_cal_bits);
      chk({modem_disable, adc_test_pins},
          {1'b1, adc_rssi, adc_i, adc_q});
      wr(8'h78, 8'h01);
      cyc(2);
      chk({modem_disable, adc_test_pins, modem_i, modem_q},
          {13'h0000, tx_i, tx_q});
      wr(8'h78, 8'h40);
      cyc(2);
      chk({subsample_mux_alt, modem_i, modem_q},
          {1'b1, adc_i, adc_q});
      wr(8'h70, 8'h1E);
      wr(8'h78, 8'h20);
      cyc(3);
      chk({test_strobe, test_pins}, xor_high_rate);
      wr(8'h78, 8'h80);
      cyc(3);
      p = pn_fault_data;
      cyc(1);
      chk(pn_fault_data != p, 1'b1);
      wr(8'h78, 8'h10);
      cyc(3);
      chk(pn_fault_data, 9'h000);
      p = {test_strobe, test_pins};
      cyc(1);
      chk({test_strobe, test_pins} != p, 1'b1);
      wr(8'h78, 8'h00);
      cyc(3);
      chk({subsample_mux_alt, test_strobe, test_pins}, 10'h000);
   endtask

   task automatic gap(output int n);
      for (n = 0; n < 2000 && cal_update_tick !== 1'b1; n++) cyc(1);
      for (n = 1; n < 2000; n++) begin
         cyc(1);
         if (cal_update_tick === 1'b1) break;
      end
   endtask

   task automatic t_cal();
      int n;
      gap(n);
      gap(n);
      chk(18'(n), 18'(SLOW));
      wr(8'h78, 8'h08);
      gap(n);
      gap(n);
      chk(18'(n), 18'(test_bus_pkg::CAL_FAST_CYCLES));
      wr(8'h78, 8'h00);
   endtask

   task automatic t_ed();
      realtime t0;
      int n;
      energy_compare <= 1'b1;
      rpe_rise();
      t0 = $realtime;
      dwell();
      chk(energy_detect, 1'b1);
      for (n = 0; n < 1000 && energy_detect_run === 1'b1; n++) cyc(1);
      n = int'(($realtime - t0) / 50.0);
      chk(n >= 378 && n <= 384, 1'b1);
      @(posedge clk);
      energy_compare <= 1'b0;
      dwell();
      chk(energy_detect, 1'b1);
      wr(8'h7C, 8'h02);
      rpe_rise();
      cyc(500);
      dwell();
      chk({energy_detect_run, energy_detect}, 2'b10);
      wr(8'h7C, 8'h00);
      raw_channel_clear <= 1'b1;
      dwell();
      chk(channel_clear_indication, 1'b1);
      @(posedge clk);
      raw_channel_clear <= 1'b0;
      dwell();
      chk(channel_clear_indication, 1'b0);
      wr(8'h7C, 8'h01);
      rpe_rise();
      raw_channel_clear <= 1'b1;
      dwell();
      @(posedge clk);
      raw_channel_clear <= 1'b0;
      dwell();
      chk(channel_clear_indication, 1'b1);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_sel();
      t_sq2();
      t_ctrl1();
      t_cal();
      t_ed();
      conclude();
   end

   initial begin
      #2_000_000;
      num_errors++;
      conclude();
   end
endmodule
